// ---- hdl/crx_regs.vh ----
// field positions, sizes and priority codes for the receive filter and queue block
`ifndef CRX_REGS_VH
`define CRX_REGS_VH

`define CRX_NUM_BANKS     14
`define CRX_NUM_QUEUES    2
`define CRX_QUEUE_DEPTH   3
`define CRX_SLOTS         4
`define CRX_FMI_W         8

// 32-bit filter word layout
`define CRX_W32_STD_MSB   31
`define CRX_W32_STD_LSB   21
`define CRX_W32_EXT_MSB   20
`define CRX_W32_EXT_LSB   3
`define CRX_W32_IDE       2
`define CRX_W32_RTR       1

// 16-bit filter half layout
`define CRX_W16_STD_MSB   15
`define CRX_W16_STD_LSB   5
`define CRX_W16_RTR       4
`define CRX_W16_IDE       3
`define CRX_W16_EXT_MSB   2

// stored entry layout: {data_high, data_low, fmi, dlc, id_word}
`define CRX_ENT_W         108
`define CRX_ENT_ID_LSB    0
`define CRX_ENT_DLC_LSB   32
`define CRX_ENT_FMI_LSB   36
`define CRX_ENT_DLO_LSB   44
`define CRX_ENT_DHI_LSB   76

// info word layout
`define CRX_INFO_FMI_LSB  8
`define CRX_INFO_DLC_LSB  0

// priority class, lower wins: {not 32-bit, not list}
`define CRX_RANK_W        2
`define CRX_KEY_NONE      10'h3FF

`endif

// ---- hdl/crx_filter.v ----
// one acceptance filter bank: up to four match slots
`timescale 1ns/100ps
`include "crx_regs.vh"

module crx_filter (
  input  wire [31:0] word_a_i,
  input  wire [31:0] word_b_i,
  input  wire        scale_i,
  input  wire        mode_i,
  input  wire        active_i,
  input  wire [31:0] frame32_i,
  input  wire [15:0] frame16_i,
  output reg  [3:0]  hit_o
);

  always @* begin
    hit_o = 4'h0;
    if (active_i) begin
      if (scale_i) begin
        if (mode_i) begin
          hit_o[0] = (frame32_i[31:1] == word_a_i[31:1]);
          hit_o[1] = (frame32_i[31:1] == word_b_i[31:1]);
        end else begin
          // a holds the expected bits, b the care bits
          hit_o[0] = (((frame32_i ^ word_a_i) & word_b_i) == 32'h00000000);
        end
      end else begin
        if (mode_i) begin
          hit_o[0] = (frame16_i == word_a_i[15:0]);
          hit_o[1] = (frame16_i == word_a_i[31:16]);
          hit_o[2] = (frame16_i == word_b_i[15:0]);
          hit_o[3] = (frame16_i == word_b_i[31:16]);
        end else begin
          hit_o[0] = (((frame16_i ^ word_a_i[15:0]) & word_a_i[31:16]) == 16'h0000);
          hit_o[1] = (((frame16_i ^ word_b_i[15:0]) & word_b_i[31:16]) == 16'h0000);
        end
      end
    end
  end

endmodule

// ---- hdl/crx_queue.v ----
// three-deep receive queue with the head entry always at position 0
`timescale 1ns/100ps
`include "crx_regs.vh"

module crx_queue #(
  parameter W     = `CRX_ENT_W,
  parameter DEPTH = `CRX_QUEUE_DEPTH
) (
  input  wire         ref_clk_i,
  input  wire         rst_n_i,
  input  wire         push_i,
  input  wire [W-1:0] entry_i,
  input  wire         release_i,
  input  wire         lock_i,
  input  wire         ovr_clr_i,
  output wire [W-1:0] head_o,
  output wire [1:0]   count_o,
  output wire         ovr_o
);

  reg  [W-1:0] ent_q [0:DEPTH-1];
  reg  [1:0]   count_q;
  reg          ovr_q;
  wire         rel;
  wire         full;
  wire [1:0]   wr_pos;

  // release of an empty queue is ignored
  assign rel    = release_i && (count_q != 2'h0);
  assign full   = (count_q == DEPTH[1:0]);
  // unless the queue is full, a shift in the same cycle makes the new frame land one place lower; a full queue writes the last place
  assign wr_pos = full ? (rel ? DEPTH[1:0] - 2'h1 : DEPTH[1:0] - 2'h1) : (count_q - {1'b0, rel});
  assign head_o  = ent_q[0];
  assign count_o = count_q;
  assign ovr_o   = ovr_q;

  genvar e;
  generate
    for (e = 0; e < DEPTH; e = e + 1) begin : g_ent
      always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          ent_q[e] <= {W{1'b0}};
        end else begin
          if (push_i && wr_pos == e && !(full && !rel && lock_i)) begin
            ent_q[e] <= entry_i;
          end else if (rel && e < DEPTH - 1) begin
            ent_q[e] <= ent_q[e+1];
          end
        end
      end
    end
  endgenerate

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      count_q <= 2'h0;
      ovr_q   <= 1'b0;
    end else begin
      if (push_i && !rel && !full) begin
        count_q <= count_q + 2'h1;
      end else if (rel && !push_i) begin
        count_q <= count_q - 2'h1;
      end
      // set wins over a clear in the same cycle
      if (push_i && full && !rel) begin
        ovr_q <= 1'b1;
      end else if (ovr_clr_i) begin
        ovr_q <= 1'b0;
      end
    end
  end

endmodule

// ---- hdl/crx_top.v ----
// receive side of the controller: filter banks, priority pick and two receive queues
`timescale 1ns/100ps
`include "crx_regs.vh"

// Behaviour
// - two three-deep queues, bank picks queue
// - two-bit pending count per queue
// - release frees oldest, next frame shown
// - push into full queue sets overflow
// - lock on: keep stored, drop new
// - lock off: newest stored frame overwritten
// - gated interrupt on new, full, overflow
// - fourteen banks, unmatched frames dropped
// - scale bit: one 32 or two 16
// - mode bit: mask or identifier list
// - activation bit; disabled bank never matches
// - assignment bit selects destination queue
// - mask mode: identifier plus care register
// - 32-bit word identifier bit layout
// - list mode: equal to either word
// - 16-bit: two mask or four list
// - 16-bit half identifier bit layout
// - eight-bit matching filter index stored
// - priority: 32 over 16, list, lower
module crx_top #(
  parameter NB = `CRX_NUM_BANKS
) (
  input  wire          ref_clk_i,
  input  wire          rst_n_i,
  input  wire          frm_valid_i,
  input  wire [10:0]   frm_standard_identifier_i,
  input  wire [17:0]   frm_extended_identifier_i,
  input  wire          frm_ide_i,
  input  wire          frm_rtr_i,
  input  wire [3:0]    frm_dlc_i,
  input  wire [31:0]   frm_data_low_i,
  input  wire [31:0]   frm_data_high_i,
  input  wire [NB*32-1:0] filter_bank_word_a_i,
  input  wire [NB*32-1:0] filter_bank_word_b_i,
  input  wire [NB-1:0] filter_scale_config_i,
  input  wire [NB-1:0] filter_mode_config_i,
  input  wire [NB-1:0] filter_activation_i,
  input  wire [NB-1:0] filter_queue_assign_i,
  input  wire          rx_queue_lock_enable_i,
  input  wire [1:0]    release_output_mailbox_i,
  input  wire [1:0]    overflow_clear_i,
  input  wire [1:0]    new_msg_irq_en_i,
  input  wire [1:0]    full_irq_en_i,
  input  wire [1:0]    overflow_irq_en_i,
  output wire [63:0]   rx_mailbox_id_word_o,
  output wire [63:0]   rx_mailbox_info_word_o,
  output wire [63:0]   rx_mailbox_data_low_o,
  output wire [63:0]   rx_mailbox_data_high_o,
  output wire [3:0]    pending_count_field_o,
  output reg  [1:0]    queue_full_o,
  output wire [1:0]    queue_overflow_flag_o,
  output reg  [1:0]    rx_irq_o,
  output reg           frame_accept_o,
  output reg           frame_reject_o
);

  wire [31:0]    frame32;
  wire [15:0]    frame16;
  wire [NB*4-1:0] hit;

  assign frame32 = {frm_standard_identifier_i, frm_extended_identifier_i,
                    frm_ide_i, frm_rtr_i, 1'b0};
  assign frame16 = {frm_standard_identifier_i, frm_rtr_i, frm_ide_i,
                    frm_extended_identifier_i[17:15]};

  genvar gb;
  generate
    for (gb = 0; gb < NB; gb = gb + 1) begin : g_bank
      crx_filter u_filter (
        .word_a_i  (filter_bank_word_a_i[gb*32 +: 32]),
        .word_b_i  (filter_bank_word_b_i[gb*32 +: 32]),
        .scale_i   (filter_scale_config_i[gb]),
        .mode_i    (filter_mode_config_i[gb]),
        .active_i  (filter_activation_i[gb]),
        .frame32_i (frame32),
        .frame16_i (frame16),
        .hit_o     (hit[gb*4 +: 4])
      );
    end
  endgenerate

  // priority pick over every slot of every bank
  reg [7:0]  base0;
  reg [7:0]  base1;
  reg [7:0]  base;
  reg [7:0]  idx;
  reg [2:0]  nidx;
  reg [2:0]  s;
  reg [9:0]  key;
  reg [9:0]  best_key;
  reg        best_vld;
  reg        best_q;
  integer    b;

  always @* begin
    base0    = 8'h00;
    base1    = 8'h00;
    base     = 8'h00;
    idx      = 8'h00;
    nidx     = 3'h0;
    key      = `CRX_KEY_NONE;
    best_key = `CRX_KEY_NONE;
    best_vld = 1'b0;
    best_q   = 1'b0;
    for (b = 0; b < NB; b = b + 1) begin
      // disabled banks still take their indices
      if (filter_scale_config_i[b]) begin
        nidx = filter_mode_config_i[b] ? 3'h2 : 3'h1;
      end else begin
        nidx = filter_mode_config_i[b] ? 3'h4 : 3'h2;
      end
      base = filter_queue_assign_i[b] ? base1 : base0;
      for (s = 3'h0; s < 3'h4; s = s + 3'h1) begin
        idx = base + {5'h00, s};
        key = {~filter_scale_config_i[b], ~filter_mode_config_i[b], idx};
        if (hit[b*4 + s] && (!best_vld || key < best_key)) begin
          best_vld = 1'b1;
          best_key = key;
          best_q   = filter_queue_assign_i[b];
        end
      end
      if (filter_queue_assign_i[b]) begin
        base1 = base1 + {5'h00, nidx};
      end else begin
        base0 = base0 + {5'h00, nidx};
      end
    end
  end

  // one register stage between the match and the queue write
  reg                  acc_vld_q;
  reg                  acc_q_q;
  reg [`CRX_ENT_W-1:0] acc_ent_q;

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      acc_vld_q      <= 1'b0;
      acc_q_q        <= 1'b0;
      acc_ent_q      <= {`CRX_ENT_W{1'b0}};
      frame_accept_o <= 1'b0;
      frame_reject_o <= 1'b0;
    end else begin
      acc_vld_q      <= frm_valid_i && best_vld;
      frame_accept_o <= frm_valid_i && best_vld;
      frame_reject_o <= frm_valid_i && !best_vld;
      if (frm_valid_i && best_vld) begin
        acc_q_q   <= best_q;
        acc_ent_q <= {frm_data_high_i, frm_data_low_i, best_key[7:0],
                      frm_dlc_i, frame32};
      end
    end
  end

  wire [`CRX_ENT_W-1:0] head   [0:1];
  wire [1:0]            cnt    [0:1];
  wire [1:0]            ovr;

  genvar gq;
  generate
    for (gq = 0; gq < 2; gq = gq + 1) begin : g_queue
      crx_queue #(
        .W     (`CRX_ENT_W),
        .DEPTH (`CRX_QUEUE_DEPTH)
      ) u_queue (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .push_i    (acc_vld_q && (acc_q_q == gq)),
        .entry_i   (acc_ent_q),
        .release_i (release_output_mailbox_i[gq]),
        .lock_i    (rx_queue_lock_enable_i),
        .ovr_clr_i (overflow_clear_i[gq]),
        .head_o    (head[gq]),
        .count_o   (cnt[gq]),
        .ovr_o     (ovr[gq])
      );

      assign rx_mailbox_id_word_o[gq*32 +: 32]   = head[gq][`CRX_ENT_ID_LSB +: 32];
      assign rx_mailbox_data_low_o[gq*32 +: 32]  = head[gq][`CRX_ENT_DLO_LSB +: 32];
      assign rx_mailbox_data_high_o[gq*32 +: 32] = head[gq][`CRX_ENT_DHI_LSB +: 32];
      assign rx_mailbox_info_word_o[gq*32 +: 32] = {16'h0000,
                                                   head[gq][`CRX_ENT_FMI_LSB +: 8],
                                                   4'h0,
                                                   head[gq][`CRX_ENT_DLC_LSB +: 4]};
      assign pending_count_field_o[gq*2 +: 2]    = cnt[gq];
      assign queue_overflow_flag_o[gq]           = ovr[gq];
    end
  endgenerate

  // level interrupt per queue; follows state one cycle late
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_irq_o     <= 2'h0;
      queue_full_o <= 2'h0;
    end else begin
      queue_full_o[0] <= (cnt[0] == 2'h3);
      queue_full_o[1] <= (cnt[1] == 2'h3);
      rx_irq_o[0] <= (new_msg_irq_en_i[0] && cnt[0] != 2'h0) ||
                     (full_irq_en_i[0] && cnt[0] == 2'h3) ||
                     (overflow_irq_en_i[0] && ovr[0]);
      rx_irq_o[1] <= (new_msg_irq_en_i[1] && cnt[1] != 2'h0) ||
                     (full_irq_en_i[1] && cnt[1] == 2'h3) ||
                     (overflow_irq_en_i[1] && ovr[1]);
    end
  end

endmodule

// ---- verif/crx_top_properties.sv ----
// assertions on the frame answer, queue 0 count, overflow and interrupt outputs
`timescale 1ns/100ps
module crx_top_properties (
  input wire       ref_clk_i,
  input wire       rst_n_i,
  input wire       frm_valid_i,
  input wire [1:0] release_output_mailbox_i,
  input wire [1:0] overflow_clear_i,
  input wire [1:0] new_msg_irq_en_i,
  input wire [1:0] full_irq_en_i,
  input wire [1:0] overflow_irq_en_i,
  input wire [3:0] pending_count_field_o,
  input wire [1:0] queue_full_o,
  input wire [1:0] queue_overflow_flag_o,
  input wire [1:0] rx_irq_o,
  input wire       frame_accept_o,
  input wire       frame_reject_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [1:0] c0 = pending_count_field_o[1:0];
  property p_answer; frm_valid_i |=> (frame_accept_o ^ frame_reject_o); endproperty
  a_answer: assert property (p_answer) else $error("frame got no single verdict");
  property p_quiet; !frm_valid_i |=> !frame_accept_o && !frame_reject_o; endproperty
  a_quiet: assert property (p_quiet) else $error("verdict without a frame");
  property p_cnt_cause; $past(rst_n_i) && c0 != $past(c0) |-> $past(frame_accept_o) || $past(release_output_mailbox_i[0]); endproperty
  a_cnt_cause: assert property (p_cnt_cause) else $error("count moved without push or release");
  property p_release; release_output_mailbox_i[0] && c0 != 2'h0 && !frame_accept_o |=> c0 == $past(c0) - 2'h1; endproperty
  a_release: assert property (p_release) else $error("release did not decrement count");
  property p_full; $past(rst_n_i) |-> queue_full_o[0] == ($past(c0) == 2'h3); endproperty
  a_full: assert property (p_full) else $error("full flag disagrees with count");
  property p_ovr_cause; $rose(queue_overflow_flag_o[0]) |-> $past(c0) == 2'h3 && $past(frame_accept_o); endproperty
  a_ovr_cause: assert property (p_ovr_cause) else $error("overflow without push into full queue");
  property p_hold_full; c0 == 2'h3 && !release_output_mailbox_i[0] |=> c0 == 2'h3; endproperty
  a_hold_full: assert property (p_hold_full) else $error("full count changed without release");
  property p_sticky; queue_overflow_flag_o[0] && !overflow_clear_i[0] |=> queue_overflow_flag_o[0]; endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped uncleared");
  property p_irq_new; new_msg_irq_en_i[0] && c0 != 2'h0 |=> rx_irq_o[0]; endproperty
  a_irq_new: assert property (p_irq_new) else $error("pending frame raised no interrupt");
  property p_irq_off; !(new_msg_irq_en_i[0] || full_irq_en_i[0] || overflow_irq_en_i[0]) |=> !rx_irq_o[0]; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt with all enables off");
endmodule
bind crx_top crx_top_properties u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .frm_valid_i(frm_valid_i),
  .release_output_mailbox_i(release_output_mailbox_i), .overflow_clear_i(overflow_clear_i),
  .new_msg_irq_en_i(new_msg_irq_en_i), .full_irq_en_i(full_irq_en_i), .overflow_irq_en_i(overflow_irq_en_i),
  .pending_count_field_o(pending_count_field_o), .queue_full_o(queue_full_o),
  .queue_overflow_flag_o(queue_overflow_flag_o), .rx_irq_o(rx_irq_o), .frame_accept_o(frame_accept_o),
  .frame_reject_o(frame_reject_o));

// ---- verif/crx_frame_src.sv ----
// behavioural protocol engine handing validated frames to the receive block
`timescale 1ns/100ps
module crx_frame_src (
  input  wire        ref_clk_i,
  output reg         valid_o,
  output reg  [10:0] std_o,
  output reg  [17:0] ext_o,
  output reg         ide_o,
  output reg         rtr_o,
  output reg  [3:0]  dlc_o,
  output reg  [31:0] lo_o,
  output reg  [31:0] hi_o
);
  initial begin
    valid_o = 1'b0;
    {std_o, ext_o, ide_o, rtr_o, dlc_o, lo_o, hi_o} = {99{1'b0}};
  end
  task frame(input [10:0] s, input [17:0] e, input i, input r, input [3:0] d, input [31:0] lo);
    begin
      #1;
      valid_o = 1'b1;
      {std_o, ext_o, ide_o, rtr_o, dlc_o, lo_o, hi_o} = {s, e, i, r, d, lo, ~lo};
      @(posedge ref_clk_i);
    end
  endtask
  // fields are unqualified between frames: scramble them so stale values cannot pass for a frame
  task idle;
    begin
      #1;
      valid_o = 1'b0;
      {std_o, ext_o, ide_o, rtr_o, dlc_o, lo_o, hi_o} = ~{std_o, ext_o, ide_o, rtr_o, dlc_o, lo_o, hi_o};
    end
  endtask
endmodule

// ---- verif/crx_top_bench.sv ----
// self-checking bench: filter table rows, then overflow policies and release
`timescale 1ns/100ps
module crx_top_bench;
  reg          clk, rst_n, lock;
  reg  [447:0] wa, wb;
  reg  [13:0]  scl, mode, act, asg;
  reg  [1:0]   rel, oclr, ien;
  wire         valid, ide, rtr, acc, rej;
  wire [10:0]  std;
  wire [17:0]  ext;
  wire [3:0]   dlc, cnt;
  wire [31:0]  dlo, dhi;
  wire [63:0]  idw, info, dl, dh;
  wire [1:0]   full, ovr, irq;
  reg  [40:0]  rows [0:8];
  reg  [10:0]  s;
  reg  [17:0]  e;
  reg          id, r, a, q;
  reg  [7:0]   f;
  integer      n_fail, total_checks, i, j;
  crx_frame_src u_src (.ref_clk_i(clk), .valid_o(valid), .std_o(std), .ext_o(ext), .ide_o(ide), .rtr_o(rtr),
    .dlc_o(dlc), .lo_o(dlo), .hi_o(dhi));
  crx_top u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .frm_valid_i(valid), .frm_standard_identifier_i(std),
    .frm_extended_identifier_i(ext), .frm_ide_i(ide), .frm_rtr_i(rtr), .frm_dlc_i(dlc), .frm_data_low_i(dlo),
    .frm_data_high_i(dhi), .filter_bank_word_a_i(wa), .filter_bank_word_b_i(wb), .filter_scale_config_i(scl),
    .filter_mode_config_i(mode), .filter_activation_i(act), .filter_queue_assign_i(asg),
    .rx_queue_lock_enable_i(lock), .release_output_mailbox_i(rel), .overflow_clear_i(oclr),
    .new_msg_irq_en_i(ien), .full_irq_en_i(ien), .overflow_irq_en_i(ien), .rx_mailbox_id_word_o(idw),
    .rx_mailbox_info_word_o(info), .rx_mailbox_data_low_o(dl), .rx_mailbox_data_high_o(dh),
    .pending_count_field_o(cnt), .queue_full_o(full), .queue_overflow_flag_o(ovr), .rx_irq_o(irq),
    .frame_accept_o(acc), .frame_reject_o(rej));
  function [31:0] w32(input [10:0] s, input [17:0] e, input i, input r);
    w32 = {s, e, i, r, 1'b0};
  endfunction
  function [15:0] w16(input [10:0] s, input [17:0] e, input i, input r);
    w16 = {s, r, i, e[17:15]};
  endfunction
  task chk(input [127:0] got, input [127:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task release_q(input qq);
    begin
      #1 rel[qq] = 1'b1;
      @(posedge clk);
      #1 rel = 2'b00;
    end
  endtask
  task finish_test;
    begin
      $display("checks=%0d failures=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail = n_fail + 1;
    finish_test;
  end
  initial begin
    n_fail = 0; total_checks = 0; rst_n = 1'b0; lock = 1'b0; rel = 2'h0; oclr = 2'h0; ien = 2'h0;
    wa = 448'h0; wb = 448'h0; scl = 14'h0; mode = 14'h0; act = 14'h1F; asg = 14'h2; act[3] = 1'b0;
    wa[0+:32] = w32(11'h100, 0, 0, 0); wb[0+:32] = 32'hFFE00000; scl[0] = 1'b1;
    wa[32+:32] = {w16(11'h301, 0, 0, 0), w16(11'h300, 0, 0, 0)}; mode[1] = 1'b1;
    wb[32+:32] = {w16(11'h100, 0, 0, 0), w16(11'h302, 0, 0, 0)};
    wa[64+:32] = w32(11'h100, 0, 0, 0); wb[64+:32] = w32(11'h200, 18'h3, 1, 0); scl[2] = 1'b1; mode[2] = 1'b1;
    wa[96+:32] = {16'hFFE0, w16(11'h400, 0, 0, 0)};
    wa[128+:32] = {16'hFFE0, w16(11'h500, 0, 0, 0)}; wb[128+:32] = {16'hFF00, w16(11'h600, 0, 0, 0)};
    rows[0] = {11'h100, 18'h0, 4'b0010, 8'h01};
    rows[1] = {11'h200, 18'h3, 4'b1010, 8'h02};
    rows[2] = {11'h100, 18'h2AAAA, 4'b1110, 8'h00};
    rows[3] = {11'h302, 18'h0, 4'b0011, 8'h02};
    rows[4] = {11'h301, 18'h0, 4'b0011, 8'h01};
    rows[5] = {11'h400, 18'h0, 4'b0000, 8'h00};
    rows[6] = {11'h500, 18'h0, 4'b0010, 8'h05};
    rows[7] = {11'h603, 18'h0, 4'b0010, 8'h06};
    rows[8] = {11'h7FF, 18'h0, 4'b0000, 8'h00};
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({cnt, full, ovr, irq, acc, rej}, 0);
    for (i = 0; i < 9; i = i + 1) begin
      {s, e, id, r, a, q, f} = rows[i];
      u_src.frame(s, e, id, r, i[3:0], 32'h1000 + i);
      u_src.idle;
      chk({acc, rej}, {a, !a});
      @(posedge clk);
      #1 chk(cnt[q*2+:2], a);
      if (a) begin
        chk(info[q*32+:32], {16'h0, f, 4'h0, i[3:0]});
        chk({idw[q*32+:32], dl[q*32+:32], dh[q*32+:32]}, {w32(s, e, id, r), 32'h1000 + i, ~(32'h1000 + i)});
        release_q(q);
        chk(cnt, 0);
      end
    end
    for (j = 0; j < 2; j = j + 1) begin
      lock = j[0]; ien = 2'h3;
      for (i = 0; i < 4; i = i + 1) u_src.frame(11'h200, 18'h3, 1, 0, 4'h8, 32'hC0 + i);
      u_src.idle;
      repeat (3) @(posedge clk);
      #1 chk({cnt[1:0], full[0], ovr[0], irq[0], dl[31:0]}, {2'h3, 3'h7, 32'hC0});
      release_q(0);
      release_q(0);
      chk({cnt[1:0], dl[31:0]}, {2'h1, j ? 32'hC2 : 32'hC3});
      release_q(0);
      release_q(0);
      chk({cnt, ovr[0]}, 5'h1);
      #1 oclr = 2'h1; ien = 2'h0;
      @(posedge clk);
      #1 oclr = 2'h0;
      @(posedge clk);
      #1 chk({ovr, irq}, 0);
    end
    // reset in mid-run with a frame stored, then a frame on the first edge after release
    u_src.frame(11'h200, 18'h3, 1, 0, 4'h8, 32'hD0);
    u_src.idle;
    @(posedge clk);
    #1 chk(cnt, 4'h1);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({cnt, full, ovr, irq, acc, rej, dl[31:0]}, 0);
    u_src.frame(11'h200, 18'h3, 1, 0, 4'h8, 32'hD1);
    u_src.idle;
    @(posedge clk);
    #1 chk({cnt, dl[31:0]}, {4'h1, 32'hD1});
    finish_test;
  end
endmodule
